// >>> rtl/crao_calendar.sv
// Purpose: calendar registers (minute to year) and alarm-one seconds/minutes with match logic
// Assumes: register port comes from the serial bus engine on ref_clk; sec_tick is a one-cycle
//          enable once per second from the seconds block, which also supplies the seconds value
// Notes:   a host write wins over a calendar advance in the same cycle
`timescale 1ns/1ps
module crao_calendar
  import crao_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       sec_tick,
  input  wire logic [7:0] seconds_bcd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] alarm_one_hours,
  input  wire logic [7:0] alarm_one_daydate,
  input  wire logic       alarm_one_irq_enable,
  input  wire logic       alarm_one_flag,
  output logic            alarm_one_set,
  output logic            irq_or_clock_in_pin
);

  // register storage
  logic [7:0] time_minutes_ff;
  logic [7:0] time_hours_ff;
  logic [7:0] weekday_value_ff;
  logic [7:0] month_day_value_ff;
  logic [7:0] month_and_century_ff;
  logic [7:0] year_value_ff;
  logic [7:0] alarm_one_seconds_ff;
  logic [7:0] alarm_one_minutes_ff;
  logic [7:0] reg_rdata_ff;
  logic       tick_seen_ff;
  logic       alarm_one_set_ff;
  logic       irq_ff;

  // write strobes
  logic wr_minutes;
  logic wr_hours;
  logic wr_weekday;
  logic wr_date;
  logic wr_month;
  logic wr_year;
  logic wr_alm_sec;
  logic wr_alm_min;

  // carry chain
  logic       sec_wrap;
  logic       min_wrap;
  logic       hour_wrap;
  logic       date_wrap;
  logic       month_wrap;
  logic       year_wrap;
  logic       min_step;
  logic       hour_step;
  logic       day_step;
  logic       month_step;
  logic       year_step;
  logic [7:0] nxt_minutes;
  logic [7:0] nxt_hours;
  logic [7:0] nxt_weekday;
  logic [7:0] nxt_date;
  logic [7:0] nxt_month;
  logic [7:0] nxt_year;
  logic [7:0] month_last_date;
  logic [7:0] month_bcd;

  // alarm compare
  logic       sec_hit;
  logic       min_hit;
  logic       hour_hit;
  logic       daydate_hit;
  logic       alarm_match;
  logic [7:0] daydate_now;
  logic [7:0] nxt_rdata;

  // address decode
  always_comb begin
    wr_minutes = reg_wr && (reg_addr == CRAO_OFF_TIME_MINUTES);
    wr_hours   = reg_wr && (reg_addr == CRAO_OFF_TIME_HOURS);
    wr_weekday = reg_wr && (reg_addr == CRAO_OFF_WEEKDAY_VALUE);
    wr_date    = reg_wr && (reg_addr == CRAO_OFF_MONTH_DAY_VALUE);
    wr_month   = reg_wr && (reg_addr == CRAO_OFF_MONTH_AND_CENTURY);
    wr_year    = reg_wr && (reg_addr == CRAO_OFF_YEAR_VALUE);
    wr_alm_sec = reg_wr && (reg_addr == CRAO_OFF_ALARM_ONE_SECONDS);
    wr_alm_min = reg_wr && (reg_addr == CRAO_OFF_ALARM_ONE_MINUTES);
  end

  // the seconds block rolls 59 to 00 on this tick, so a minute step is due
  assign sec_wrap   = (seconds_bcd[6:0] == CRAO_MAX_SEC_MIN[6:0]);
  assign min_step   = sec_tick && sec_wrap;
  assign hour_step  = min_step && min_wrap;
  assign day_step   = hour_step && hour_wrap;
  assign month_step = day_step && date_wrap;
  assign year_step  = month_step && month_wrap;
  assign month_bcd  = {3'h0, month_and_century_ff[4:0]};

  // minutes 00..59
  crao_bcd_step u_min_step (
    .cur_val    (time_minutes_ff),
    .top_val    (CRAO_MAX_SEC_MIN),
    .bottom_val (CRAO_MIN_ZERO),
    .nxt_val    (nxt_minutes),
    .wrap       (min_wrap)
  );

  // hours 00..23, 24-hour form only
  crao_bcd_step u_hour_step (
    .cur_val    ({2'h0, time_hours_ff[5:0]}),
    .top_val    (CRAO_MAX_HOUR),
    .bottom_val (CRAO_MIN_ZERO),
    .nxt_val    (nxt_hours),
    .wrap       (hour_wrap)
  );

  // weekday 1..7; its wrap is not part of the carry chain
  crao_bcd_step u_wday_step (
    .cur_val    (weekday_value_ff),
    .top_val    (CRAO_MAX_WEEKDAY),
    .bottom_val (CRAO_MIN_ONE),
    .nxt_val    (nxt_weekday),
    .wrap       ()
  );

  // last date depends on month and leap year
  crao_month_len u_month_len (
    .month_bcd (month_bcd),
    .year_bcd  (year_value_ff),
    .last_date (month_last_date)
  );

  // date 01..last
  crao_bcd_step u_date_step (
    .cur_val    (month_day_value_ff),
    .top_val    (month_last_date),
    .bottom_val (CRAO_MIN_ONE),
    .nxt_val    (nxt_date),
    .wrap       (date_wrap)
  );

  // month 01..12
  crao_bcd_step u_month_step (
    .cur_val    (month_bcd),
    .top_val    (CRAO_MAX_MONTH),
    .bottom_val (CRAO_MIN_ONE),
    .nxt_val    (nxt_month),
    .wrap       (month_wrap)
  );

  // year 00..99
  crao_bcd_step u_year_step (
    .cur_val    (year_value_ff),
    .top_val    (CRAO_MAX_YEAR),
    .bottom_val (CRAO_MIN_ZERO),
    .nxt_val    (nxt_year),
    .wrap       (year_wrap)
  );

  // minutes register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      time_minutes_ff <= CRAO_RST_TIME_MINUTES;
    end else if (wr_minutes) begin
      time_minutes_ff <= reg_wdata & CRAO_MSK_MINUTES;
    end else if (min_step) begin
      time_minutes_ff <= nxt_minutes;
    end
  end

  // hours register; bit 6 is stored as written, the host keeps it zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      time_hours_ff <= CRAO_RST_TIME_HOURS;
    end else if (wr_hours) begin
      time_hours_ff <= reg_wdata & CRAO_MSK_HOURS;
    end else if (hour_step) begin
      time_hours_ff <= {time_hours_ff[7:6], nxt_hours[5:0]};
    end
  end

  // weekday register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      weekday_value_ff <= CRAO_RST_WEEKDAY_VALUE;
    end else if (wr_weekday) begin
      weekday_value_ff <= reg_wdata & CRAO_MSK_WEEKDAY;
    end else if (day_step) begin
      weekday_value_ff <= nxt_weekday & CRAO_MSK_WEEKDAY;
    end
  end

  // date register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      month_day_value_ff <= CRAO_RST_MONTH_DAY_VALUE;
    end else if (wr_date) begin
      month_day_value_ff <= reg_wdata & CRAO_MSK_DATE;
    end else if (day_step) begin
      month_day_value_ff <= nxt_date & CRAO_MSK_DATE;
    end
  end

  // month register with the century bit above it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      month_and_century_ff <= CRAO_RST_MONTH_AND_CENTURY;
    end else if (wr_month) begin
      month_and_century_ff <= reg_wdata & CRAO_MSK_MONTH;
    end else if (month_step) begin
      // any month step while the year reads 99 toggles the century bit
      month_and_century_ff <= {month_and_century_ff[CRAO_BIT_CENTURY] ^ year_wrap, 2'h0,
                               nxt_month[4:0]};
    end
  end

  // year register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      year_value_ff <= CRAO_RST_YEAR_VALUE;
    end else if (wr_year) begin
      year_value_ff <= reg_wdata & CRAO_MSK_YEAR;
    end else if (year_step) begin
      year_value_ff <= nxt_year;
    end
  end

  // alarm-one seconds and minutes; hours and day/date live next door at 0Fh/10h
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_one_seconds_ff <= CRAO_RST_ALARM_ONE_SECONDS;
      alarm_one_minutes_ff <= CRAO_RST_ALARM_ONE_MINUTES;
    end else begin
      if (wr_alm_sec) begin
        alarm_one_seconds_ff <= reg_wdata;
      end
      if (wr_alm_min) begin
        alarm_one_minutes_ff <= reg_wdata;
      end
    end
  end

  // field compares; a set mask bit makes the field a don't-care
  always_comb begin
    daydate_now = alarm_one_daydate[CRAO_BIT_WEEKDAY_SEL] ? weekday_value_ff
                                                           : month_day_value_ff;
    sec_hit     = alarm_one_seconds_ff[CRAO_BIT_ALARM_MASK] ||
                  ((seconds_bcd & CRAO_CMP_SEC_MIN) == (alarm_one_seconds_ff & CRAO_CMP_SEC_MIN));
    min_hit     = alarm_one_minutes_ff[CRAO_BIT_ALARM_MASK] ||
                  ((time_minutes_ff & CRAO_CMP_SEC_MIN) == (alarm_one_minutes_ff & CRAO_CMP_SEC_MIN));
    hour_hit    = alarm_one_hours[CRAO_BIT_ALARM_MASK] ||
                  ((time_hours_ff & CRAO_CMP_HOUR) == (alarm_one_hours & CRAO_CMP_HOUR));
    daydate_hit = alarm_one_daydate[CRAO_BIT_ALARM_MASK] ||
                  ((daydate_now & CRAO_CMP_DAYDATE) == (alarm_one_daydate & CRAO_CMP_DAYDATE));
    // unlisted mask mixes just act as per-field don't-cares
    alarm_match = sec_hit && min_hit && hour_hit && daydate_hit;
  end

  // compare one cycle after the tick, once the whole time has settled
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_seen_ff <= 1'b0;
    end else begin
      tick_seen_ff <= sec_tick;
    end
  end

  // one flag-set pulse per matching second, so the rate follows the masks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_one_set_ff <= 1'b0;
    end else begin
      alarm_one_set_ff <= tick_seen_ff && alarm_match;
    end
  end

  // interrupt pin follows the sticky flag, gated by the enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= alarm_one_irq_enable && (alarm_one_flag || alarm_one_set_ff);
    end
  end

  // read mux; unmapped offsets read zero so neighbours can or their data in
  always_comb begin
    unique case (reg_addr)
      CRAO_OFF_TIME_MINUTES:      nxt_rdata = time_minutes_ff;
      CRAO_OFF_TIME_HOURS:        nxt_rdata = time_hours_ff;
      CRAO_OFF_WEEKDAY_VALUE:     nxt_rdata = weekday_value_ff;
      CRAO_OFF_MONTH_DAY_VALUE:   nxt_rdata = month_day_value_ff;
      CRAO_OFF_MONTH_AND_CENTURY: nxt_rdata = month_and_century_ff;
      CRAO_OFF_YEAR_VALUE:        nxt_rdata = year_value_ff;
      CRAO_OFF_ALARM_ONE_SECONDS: nxt_rdata = alarm_one_seconds_ff;
      CRAO_OFF_ALARM_ONE_MINUTES: nxt_rdata = alarm_one_minutes_ff;
      default:                    nxt_rdata = 8'h00;
    endcase
  end

  // read data is held until the next read strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata           = reg_rdata_ff;
  assign alarm_one_set       = alarm_one_set_ff;
  assign irq_or_clock_in_pin = irq_ff;

endmodule : crao_calendar

// >>> rtl/crao_pkg.sv
// Purpose: shared offsets, field positions and reset values of the calendar and alarm-one block
// Assumes: 8-bit register port driven by the two-wire serial bus engine on ref_clk
// Notes:   all time fields are packed bcd, tens digit above units digit
package crao_pkg;

  // register offsets on the serial bus register port
  localparam logic [7:0] CRAO_OFF_TIME_MINUTES      = 8'h07;
  localparam logic [7:0] CRAO_OFF_TIME_HOURS        = 8'h08;
  localparam logic [7:0] CRAO_OFF_WEEKDAY_VALUE     = 8'h09;
  localparam logic [7:0] CRAO_OFF_MONTH_DAY_VALUE   = 8'h0A;
  localparam logic [7:0] CRAO_OFF_MONTH_AND_CENTURY = 8'h0B;
  localparam logic [7:0] CRAO_OFF_YEAR_VALUE        = 8'h0C;
  localparam logic [7:0] CRAO_OFF_ALARM_ONE_SECONDS = 8'h0D;
  localparam logic [7:0] CRAO_OFF_ALARM_ONE_MINUTES = 8'h0E;

  // reset values
  localparam logic [7:0] CRAO_RST_TIME_MINUTES      = 8'h00;
  localparam logic [7:0] CRAO_RST_TIME_HOURS        = 8'h00;
  localparam logic [7:0] CRAO_RST_WEEKDAY_VALUE     = 8'h01;
  localparam logic [7:0] CRAO_RST_MONTH_DAY_VALUE   = 8'h01;
  localparam logic [7:0] CRAO_RST_MONTH_AND_CENTURY = 8'h01;
  localparam logic [7:0] CRAO_RST_YEAR_VALUE        = 8'h00;
  localparam logic [7:0] CRAO_RST_ALARM_ONE_SECONDS = 8'h00;
  localparam logic [7:0] CRAO_RST_ALARM_ONE_MINUTES = 8'h00;

  // writable bits of each register; the rest read as zero
  localparam logic [7:0] CRAO_MSK_MINUTES  = 8'h7F;
  localparam logic [7:0] CRAO_MSK_HOURS    = 8'h7F;
  localparam logic [7:0] CRAO_MSK_WEEKDAY  = 8'h07;
  localparam logic [7:0] CRAO_MSK_DATE     = 8'h3F;
  localparam logic [7:0] CRAO_MSK_MONTH    = 8'h9F;
  localparam logic [7:0] CRAO_MSK_YEAR     = 8'hFF;

  // field positions
  localparam int CRAO_BIT_CENTURY      = 7;
  localparam int CRAO_BIT_ALARM_MASK   = 7;
  localparam int CRAO_BIT_WEEKDAY_SEL  = 6;

  // compare widths of the bcd value part of each alarm byte
  localparam logic [7:0] CRAO_CMP_SEC_MIN  = 8'h7F;
  localparam logic [7:0] CRAO_CMP_HOUR     = 8'h3F;
  localparam logic [7:0] CRAO_CMP_DAYDATE  = 8'h3F;

  // rollover limits, packed bcd
  localparam logic [7:0] CRAO_MAX_SEC_MIN  = 8'h59;
  localparam logic [7:0] CRAO_MAX_HOUR     = 8'h23;
  localparam logic [7:0] CRAO_MAX_WEEKDAY  = 8'h07;
  localparam logic [7:0] CRAO_MIN_ONE      = 8'h01;
  localparam logic [7:0] CRAO_MIN_ZERO     = 8'h00;
  localparam logic [7:0] CRAO_MAX_MONTH    = 8'h12;
  localparam logic [7:0] CRAO_MAX_YEAR     = 8'h99;

  // month lengths, packed bcd
  localparam logic [7:0] CRAO_DAYS_LONG    = 8'h31;
  localparam logic [7:0] CRAO_DAYS_SHORT   = 8'h30;
  localparam logic [7:0] CRAO_DAYS_FEB     = 8'h28;
  localparam logic [7:0] CRAO_DAYS_FEB_LEAP = 8'h29;
  localparam logic [7:0] CRAO_MONTH_FEB    = 8'h02;
  localparam logic [7:0] CRAO_MONTH_APR    = 8'h04;
  localparam logic [7:0] CRAO_MONTH_JUN    = 8'h06;
  localparam logic [7:0] CRAO_MONTH_SEP    = 8'h09;
  localparam logic [7:0] CRAO_MONTH_NOV    = 8'h11;

endpackage : crao_pkg

// >>> rtl/crao_bcd_step.sv
// Purpose: one packed bcd increment with wrap from a top value to a bottom value
// Assumes: value is legal bcd; illegal codes simply count on, those below the top wrap there, those above it roll past F9 to 00
// Notes:   purely combinational, shared by every calendar field
`timescale 1ns/1ps
module crao_bcd_step
  import crao_pkg::*;
(
  input  wire logic [7:0] cur_val,
  input  wire logic [7:0] top_val,
  input  wire logic [7:0] bottom_val,
  output logic      [7:0] nxt_val,
  output logic            wrap
);

  // wrap at the top, otherwise carry the units digit into the tens digit
  always_comb begin
    wrap = (cur_val == top_val);
    if (wrap) begin
      nxt_val = bottom_val;
    end else if (cur_val[3:0] == 4'h9) begin
      nxt_val = {4'(cur_val[7:4] + 4'h1), 4'h0};
    end else begin
      nxt_val = {cur_val[7:4], 4'(cur_val[3:0] + 4'h1)};
    end
  end

endmodule : crao_bcd_step

// >>> rtl/crao_month_len.sv
// Purpose: last date of the current month in packed bcd
// Assumes: month and year are legal bcd
// Notes:   year 00 is taken as a leap year; the 100/400 exceptions are not modelled
`timescale 1ns/1ps
module crao_month_len
  import crao_pkg::*;
(
  input  wire logic [7:0] month_bcd,
  input  wire logic [7:0] year_bcd,
  output logic      [7:0] last_date
);

  logic leap_year;

  // bcd year divisible by four: even tens with units 0/4/8, odd tens with units 2/6
  always_comb begin
    if (year_bcd[4]) begin
      leap_year = (year_bcd[3:0] == 4'h2) || (year_bcd[3:0] == 4'h6);
    end else begin
      leap_year = (year_bcd[3:0] == 4'h0) || (year_bcd[3:0] == 4'h4) || (year_bcd[3:0] == 4'h8);
    end
  end

  // month length table
  always_comb begin
    if (month_bcd == CRAO_MONTH_FEB) begin
      last_date = leap_year ? CRAO_DAYS_FEB_LEAP : CRAO_DAYS_FEB;
    end else if ((month_bcd == CRAO_MONTH_APR) || (month_bcd == CRAO_MONTH_JUN) ||
                 (month_bcd == CRAO_MONTH_SEP) || (month_bcd == CRAO_MONTH_NOV)) begin
      last_date = CRAO_DAYS_SHORT;
    end else begin
      last_date = CRAO_DAYS_LONG;
    end
  end

endmodule : crao_month_len

// >>> verification/crao_calendar_properties.sv
// Purpose: port checker for the calendar and alarm-one block
// Assumes: one clock domain, async active-low reset
// Notes:   alarm byte shadows mirror host writes, all 8 bits kept
`timescale 1ns/1ps
module crao_calendar_properties
  import crao_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       sec_tick,
  input wire logic [7:0] seconds_bcd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] alarm_one_hours,
  input wire logic [7:0] alarm_one_daydate,
  input wire logic       alarm_one_irq_enable,
  input wire logic       alarm_one_flag,
  input wire logic       alarm_one_set,
  input wire logic       irq_or_clock_in_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] sh_sec_ff;
  logic [7:0] sh_min_ff;
  logic       mapped;
  // shadows let the checker see the mask bits without peeking inside
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_sec_ff <= CRAO_RST_ALARM_ONE_SECONDS;
      sh_min_ff <= CRAO_RST_ALARM_ONE_MINUTES;
    end else if (reg_wr) begin
      if (reg_addr == CRAO_OFF_ALARM_ONE_SECONDS) sh_sec_ff <= reg_wdata;
      if (reg_addr == CRAO_OFF_ALARM_ONE_MINUTES) sh_min_ff <= reg_wdata;
    end
  end
  // offsets owned by this block
  assign mapped = reg_addr >= CRAO_OFF_TIME_MINUTES && reg_addr <= CRAO_OFF_ALARM_ONE_MINUTES;
  // compare happens in the cycle after the tick
  sequence tick_all_masked;
    sec_tick ##1 (sh_sec_ff[7] && sh_min_ff[7] && alarm_one_hours[7] && alarm_one_daydate[7]);
  endsequence
  sequence tick_sec_miss;
    sec_tick ##1 (!sh_sec_ff[7] && seconds_bcd[6:0] != sh_sec_ff[6:0]);
  endsequence
  a_set_from_tick: assert property (alarm_one_set |-> $past(sec_tick, 2))
    else $error("alarm set without a tick two cycles before");
  a_set_one_cycle: assert property (alarm_one_set |=> !alarm_one_set)
    else $error("alarm set longer than one cycle");
  a_irq_needs_enable: assert property (irq_or_clock_in_pin |-> $past(alarm_one_irq_enable))
    else $error("interrupt raised while disabled");
  a_irq_on_flag: assert property ((alarm_one_irq_enable && alarm_one_flag) |=> irq_or_clock_in_pin)
    else $error("enabled flag did not raise interrupt");
  a_every_second: assert property (tick_all_masked |=> alarm_one_set)
    else $error("all-masked alarm missed a tick");
  a_sec_miss_quiet: assert property (tick_sec_miss |=> !alarm_one_set)
    else $error("alarm fired on seconds mismatch");
  a_unmapped_zero: assert property ((reg_rd && !mapped) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_alarm_sec_read: assert property ((reg_rd && reg_addr == CRAO_OFF_ALARM_ONE_SECONDS)
    |=> reg_rdata == $past(sh_sec_ff))
    else $error("alarm seconds readback wrong");
  a_alarm_min_read: assert property ((reg_rd && reg_addr == CRAO_OFF_ALARM_ONE_MINUTES)
    |=> reg_rdata == $past(sh_min_ff))
    else $error("alarm minutes readback wrong");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule : crao_calendar_properties
bind crao_calendar crao_calendar_properties i_crao_calendar_properties (.ref_clk, .arst_n, .sec_tick,
  .seconds_bcd, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alarm_one_hours, .alarm_one_daydate,
  .alarm_one_irq_enable, .alarm_one_flag, .alarm_one_set, .irq_or_clock_in_pin);

// >>> verification/crao_host_model.sv
// Purpose: host side of the register port, one byte per strobe
// Assumes: strobes last one cycle, changes land just after an edge
// Notes:   released lines show inverted data so stale values never look valid
`timescale 1ns/1ps
module crao_host_model
  import crao_pkg::*;
(
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= (a == CRAO_OFF_TIME_HOURS) ? (d & 8'hBF) : d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // data is taken one edge late; it holds until the next read anyway
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask : rd
  task automatic prog_alarm(input logic [7:0] s, input logic [7:0] m);
    wr(CRAO_OFF_ALARM_ONE_SECONDS, s);
    wr(CRAO_OFF_ALARM_ONE_MINUTES, m);
  endtask : prog_alarm
endmodule : crao_host_model

// >>> verification/test_crao_calendar.sv
// Purpose: self-checking bench for the calendar and alarm-one block
// Assumes: host model drives the register port
// Notes:   seconds block and status flag neighbours are modelled here
`timescale 1ns/1ps
module test_crao_calendar import crao_pkg::*;;
  logic       ref_clk;
  logic       arst_n;
  logic       sec_tick;
  logic [7:0] seconds_bcd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] alarm_one_hours;
  logic [7:0] alarm_one_daydate;
  logic       alarm_one_irq_enable;
  logic       alarm_one_flag;
  logic       alarm_one_set;
  logic       irq_or_clock_in_pin;
  int         fail_count;
  int         comparisons;
  crao_calendar i_crao_calendar (.ref_clk, .arst_n, .sec_tick, .seconds_bcd, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .alarm_one_hours, .alarm_one_daydate, .alarm_one_irq_enable, .alarm_one_flag,
    .alarm_one_set, .irq_or_clock_in_pin);
  crao_host_model i_crao_host_model (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // sticky status flag of the neighbour; cases clear it themselves
  always @(posedge ref_clk) begin
    if (alarm_one_set) alarm_one_flag <= 1'b1;
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  // pre value is seen with the tick, post value in the compare cycle
  task automatic tick(input logic [7:0] pre, input logic [7:0] post);
    @(posedge ref_clk);
    sec_tick <= 1'b1;
    seconds_bcd <= pre;
    @(posedge ref_clk);
    sec_tick <= 1'b0;
    seconds_bcd <= post;
  endtask : tick
  task automatic t_reset_values;
    logic [7:0] exp [8];
    logic [7:0] d;
    exp = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 8; k++) begin
      i_crao_host_model.rd(CRAO_OFF_TIME_MINUTES + 8'(k), d);
      chk_reg(d, exp[k]);
    end
  endtask : t_reset_values
  // all-ones writes show which bits are kept
  task automatic t_write_masks;
    logic [7:0] msk [8];
    logic [7:0] d;
    msk = '{8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h9F, 8'hFF, 8'hFF, 8'hFF};
    for (int k = 0; k < 8; k++) begin
      i_crao_host_model.wr(CRAO_OFF_TIME_MINUTES + 8'(k), 8'hFF);
      i_crao_host_model.rd(CRAO_OFF_TIME_MINUTES + 8'(k), d);
      chk_reg(d, msk[k]);
    end
    i_crao_host_model.wr(8'h0F, 8'h5A);
    i_crao_host_model.rd(8'h0F, d);
    chk_reg(d, 8'h00);
  endtask : t_write_masks
  // 23:59:59 plus one tick: weekday, date, month, year, century
  task automatic t_rollover;
    logic [63:0] tab [5];
    logic [7:0]  exp [6];
    logic [7:0]  d;
    tab = '{64'h07280223_01010323, 64'h03280224_04290224, 64'h05311299_06018100,
            64'h01300410_02010510, 64'h02319299_03010100};
    foreach (tab[i]) begin
      i_crao_host_model.wr(CRAO_OFF_YEAR_VALUE, tab[i][39:32]);
      i_crao_host_model.wr(CRAO_OFF_MONTH_AND_CENTURY, tab[i][47:40]);
      i_crao_host_model.wr(CRAO_OFF_MONTH_DAY_VALUE, tab[i][55:48]);
      i_crao_host_model.wr(CRAO_OFF_WEEKDAY_VALUE, tab[i][63:56]);
      i_crao_host_model.wr(CRAO_OFF_TIME_MINUTES, 8'h59);
      i_crao_host_model.wr(CRAO_OFF_TIME_HOURS, 8'h23);
      tick(8'h59, 8'h00);
      exp = '{8'h00, 8'h00, tab[i][31:24], tab[i][23:16], tab[i][15:8], tab[i][7:0]};
      for (int k = 0; k < 6; k++) begin
        i_crao_host_model.rd(CRAO_OFF_TIME_MINUTES + 8'(k), d);
        chk_reg(d, exp[k]);
      end
    end
  endtask : t_rollover
  // nibbles: masks 4..1, weekday select, field to miss, enable and expected pulse
  task automatic t_alarm;
    logic [15:0] tab [11];
    logic [15:0] e;
    tab = '{16'hF013, 16'hE001, 16'hE012, 16'hC003, 16'hC022, 16'h8003,
            16'h8032, 16'h0003, 16'h0042, 16'h0103, 16'h0142};
    foreach (tab[i]) begin
      e = tab[i];
      @(posedge ref_clk);
      alarm_one_flag <= 1'b0;
      alarm_one_irq_enable <= e[1];
      alarm_one_hours <= {e[14], 1'b0, (e[7:4] == 4'h3) ? 6'h13 : 6'h12};
      alarm_one_daydate <= {e[15], e[8], e[8] ? ((e[7:4] == 4'h4) ? 6'h04 : 6'h03)
                                              : ((e[7:4] == 4'h4) ? 6'h16 : 6'h15)};
      i_crao_host_model.wr(CRAO_OFF_TIME_MINUTES, 8'h34);
      i_crao_host_model.wr(CRAO_OFF_TIME_HOURS, 8'h12);
      i_crao_host_model.wr(CRAO_OFF_WEEKDAY_VALUE, 8'h03);
      i_crao_host_model.wr(CRAO_OFF_MONTH_DAY_VALUE, 8'h15);
      i_crao_host_model.prog_alarm({e[12], (e[7:4] == 4'h1) ? 7'h22 : 7'h21},
                                   {e[13], (e[7:4] == 4'h2) ? 7'h35 : 7'h34});
      tick(8'h20, 8'h21);
      // the pulse stands only in the cycle after the compare edge, so look right there
      @(posedge ref_clk);
      #1 chk_bit(alarm_one_set, e[0]);
      @(posedge ref_clk);
      #1 chk_bit(irq_or_clock_in_pin, e[0] & e[1]);
    end
  endtask : t_alarm
  task automatic test_done;
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // a hang costs far less than this span; the whole run needs under a thousand cycles
  initial begin
    #500000;
    fail_count++;
    test_done;
  end
  // main sequence
  initial begin
    fail_count = 0;
    comparisons = 0;
    arst_n = 1'b0;
    sec_tick = 1'b0;
    seconds_bcd = 8'h00;
    alarm_one_hours = 8'h00;
    alarm_one_daydate = 8'h00;
    alarm_one_irq_enable = 1'b0;
    alarm_one_flag = 1'b0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset_values;
    t_write_masks;
    t_rollover;
    t_alarm;
    test_done;
  end
endmodule : test_crao_calendar
